//--- common/eif_pkg.sv
`default_nettype none
package eif_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [5:0] ADDR_ENABLE   = 6'h00;
    localparam logic [5:0] ADDR_FLAG     = 6'h04;
    localparam logic [5:0] ADDR_WAKEFLAG = 6'h08;
    localparam logic [5:0] ADDR_EDGESEL  = 6'h0C;
    localparam logic [5:0] ADDR_WAKEEDGE = 6'h10;
    localparam logic [5:0] ADDR_PINMODE  = 6'h14;
    localparam logic [5:0] ADDR_WAKEMODE = 6'h18;
    localparam logic [5:0] ADDR_SYSCTL   = 6'h1C;
    localparam logic [5:0] ADDR_IRQSTAT  = 6'h20;
    localparam logic [5:0] ADDR_IRQMASK  = 6'h24;

    // ************************************************************
    // Bit positions in enable, flag, edge, mode and system control registers
    // ************************************************************
    localparam int BIT_DT = 7;
    localparam int BIT_WP = 5;
    localparam int BIT_B  = 3;
    localparam int BIT_A  = 0;
    localparam int BIT_DT_CTRL = 0;

    // Pin vector: ext a, ext b, then six wakeup pins
    localparam int NPINS   = 8;
    localparam int NWAKE   = 6;
    localparam int PIN_A   = 0;
    localparam int PIN_B   = 1;
    localparam int PIN_WK0 = 2;

    // Interrupt status bits
    localparam int NIST   = 4;
    localparam int IST_DT = 0;
    localparam int IST_WP = 1;
    localparam int IST_B  = 2;
    localparam int IST_A  = 3;

    // ************************************************************
    // Writable masks, fixed-one read patterns, reset values
    // ************************************************************
    localparam logic [7:0] EN_WR_MASK    = 8'hA9;
    localparam logic [7:0] EN_ONES       = 8'h10;
    localparam logic [7:0] FLAG_MASK     = 8'h89;
    localparam logic [7:0] FLAG_ONES     = 8'h30;
    localparam logic [7:0] WAKE_ONES     = 8'hC0;
    localparam logic [7:0] EXT_SEL_MASK  = 8'h09;
    localparam logic [7:0] EDGESEL_ONES  = 8'h70;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [5:0] RST_WAKE      = 6'h00;
    localparam logic [3:0] RST_IST       = 4'h0;
endpackage : eif_pkg
`default_nettype wire

//--- core/eif_unit.sv
`default_nettype none
module eif_unit (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    // CPU side
    input  wire logic        sleep_exec,
    output var  logic        direct_transition_req,
    output var  logic        wakeup_req,
    output var  logic        ext_req_b_req,
    output var  logic        ext_req_a_req,
    output var  logic        irq,
    // Pins
    input  wire logic        ext_req_a_pin,
    input  wire logic        ext_req_b_pin,
    input  wire logic [5:0]  wakeup_pins
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [eif_pkg::NPINS-1:0] sync1;
        logic [eif_pkg::NPINS-1:0] sync2;
        logic [eif_pkg::NPINS-1:0] prev;
        logic [7:0]                en;
        logic [7:0]                flag;
        logic [eif_pkg::NWAKE-1:0] wflag;
        logic [7:0]                esel;
        logic [eif_pkg::NWAKE-1:0] wsel;
        logic [7:0]                pmode;
        logic [eif_pkg::NWAKE-1:0] wmode;
        logic                      dt_ctrl;
        logic [eif_pkg::NIST-1:0]  ist;
        logic [eif_pkg::NIST-1:0]  imask;
        logic [31:0]               rdata;
        logic                      wreq;
        logic                      dt_req;
        logic                      wk_req;
        logic                      b_req;
        logic                      a_req;
        logic                      irq;
    } eif_state_s;

    eif_state_s q;
    eif_state_s next_q;

    function automatic logic edge_hit(input logic old_v, input logic new_v, input logic rise);
        edge_hit = rise ? (!old_v && new_v) : (old_v && !new_v);
    endfunction

    function automatic logic at(input logic [5:0] a, input logic [5:0] off);
        at = (a == off);
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic                      req;
    logic                      take;
    logic                      wr_ok;
    logic [7:0]                wd;
    logic [eif_pkg::NPINS-1:0] sel;
    logic [eif_pkg::NPINS-1:0] des;
    logic [eif_pkg::NPINS-1:0] hit;
    logic                      ev_dt;
    logic [eif_pkg::NIST-1:0]  ev;
    logic [7:0]                rd;

    assign req   = avs_read || avs_write;
    // Writes and read side effects happen on the edge that sees waitrequest low
    assign take  = req && !q.wreq;
    assign wr_ok = take && avs_write && avs_byteenable[0];
    assign wd    = avs_writedata[7:0];
    assign sel   = {q.wsel, q.esel[eif_pkg::BIT_B], q.esel[eif_pkg::BIT_A]};
    assign des   = {q.wmode, q.pmode[eif_pkg::BIT_B], q.pmode[eif_pkg::BIT_A]};
    assign ev_dt = sleep_exec && q.dt_ctrl;

    always_comb begin
        for (int i = 0; i < eif_pkg::NPINS; i++) begin
            hit[i] = des[i] && edge_hit(q.prev[i], q.sync2[i], sel[i]);
        end
        ev = '0;
        ev[eif_pkg::IST_DT] = ev_dt;
        ev[eif_pkg::IST_WP] = |hit[eif_pkg::NPINS-1:eif_pkg::PIN_WK0];
        ev[eif_pkg::IST_B]  = hit[eif_pkg::PIN_B];
        ev[eif_pkg::IST_A]  = hit[eif_pkg::PIN_A];
    end

    always_comb begin
        rd = eif_pkg::RST_BYTE;
        if (at(avs_address, eif_pkg::ADDR_ENABLE)) begin
            rd = q.en | eif_pkg::EN_ONES;
        end else if (at(avs_address, eif_pkg::ADDR_FLAG)) begin
            rd = q.flag | eif_pkg::FLAG_ONES;
        end else if (at(avs_address, eif_pkg::ADDR_WAKEFLAG)) begin
            rd = {2'b00, q.wflag} | eif_pkg::WAKE_ONES;
        end else if (at(avs_address, eif_pkg::ADDR_EDGESEL)) begin
            rd = q.esel | eif_pkg::EDGESEL_ONES;
        end else if (at(avs_address, eif_pkg::ADDR_WAKEEDGE)) begin
            rd = {2'b00, q.wsel} | eif_pkg::WAKE_ONES;
        end else if (at(avs_address, eif_pkg::ADDR_PINMODE)) begin
            rd = q.pmode;
        end else if (at(avs_address, eif_pkg::ADDR_WAKEMODE)) begin
            rd = {2'b00, q.wmode};
        end else if (at(avs_address, eif_pkg::ADDR_SYSCTL)) begin
            rd = {7'h00, q.dt_ctrl};
        end else if (at(avs_address, eif_pkg::ADDR_IRQSTAT)) begin
            rd = {4'h0, q.ist};
        end else if (at(avs_address, eif_pkg::ADDR_IRQMASK)) begin
            rd = {4'h0, q.imask};
        end
    end

    always_comb begin
        next_q       = q;
        next_q.sync1 = {wakeup_pins, ext_req_b_pin, ext_req_a_pin};
        next_q.sync2 = q.sync1;
        next_q.prev  = q.sync2;
        // One-cycle answer: waitrequest drops for exactly one cycle per access
        next_q.wreq  = !(req && q.wreq);
        if (req && q.wreq) begin
            next_q.rdata = {24'h000000, rd};
        end
        if (wr_ok) begin
            if (at(avs_address, eif_pkg::ADDR_ENABLE)) begin
                next_q.en = wd & eif_pkg::EN_WR_MASK;
            end
            if (at(avs_address, eif_pkg::ADDR_EDGESEL)) begin
                next_q.esel = wd & eif_pkg::EXT_SEL_MASK;
            end
            if (at(avs_address, eif_pkg::ADDR_WAKEEDGE)) begin
                next_q.wsel = wd[eif_pkg::NWAKE-1:0];
            end
            if (at(avs_address, eif_pkg::ADDR_PINMODE)) begin
                next_q.pmode = wd & eif_pkg::EXT_SEL_MASK;
            end
            if (at(avs_address, eif_pkg::ADDR_WAKEMODE)) begin
                next_q.wmode = wd[eif_pkg::NWAKE-1:0];
            end
            if (at(avs_address, eif_pkg::ADDR_SYSCTL)) begin
                next_q.dt_ctrl = wd[eif_pkg::BIT_DT_CTRL];
            end
            if (at(avs_address, eif_pkg::ADDR_IRQMASK)) begin
                next_q.imask = wd[eif_pkg::NIST-1:0];
            end
            // Write-0 clears, write-1 keeps
            if (at(avs_address, eif_pkg::ADDR_FLAG)) begin
                next_q.flag = q.flag & wd & eif_pkg::FLAG_MASK;
            end
            if (at(avs_address, eif_pkg::ADDR_WAKEFLAG)) begin
                next_q.wflag = q.wflag & wd[eif_pkg::NWAKE-1:0];
            end
        end
        // Hardware set wins over a colliding clear, so no request is lost
        next_q.flag[eif_pkg::BIT_DT] = next_q.flag[eif_pkg::BIT_DT] | ev_dt;
        next_q.flag[eif_pkg::BIT_B]  = next_q.flag[eif_pkg::BIT_B] | hit[eif_pkg::PIN_B];
        next_q.flag[eif_pkg::BIT_A]  = next_q.flag[eif_pkg::BIT_A] | hit[eif_pkg::PIN_A];
        next_q.wflag = next_q.wflag | hit[eif_pkg::NPINS-1:eif_pkg::PIN_WK0];
        if (take && avs_read && at(avs_address, eif_pkg::ADDR_IRQSTAT)) begin
            next_q.ist = eif_pkg::RST_IST;
        end
        next_q.ist    = next_q.ist | ev;
        next_q.dt_req = q.flag[eif_pkg::BIT_DT] && q.en[eif_pkg::BIT_DT];
        next_q.wk_req = (|q.wflag) && q.en[eif_pkg::BIT_WP];
        next_q.b_req  = q.flag[eif_pkg::BIT_B] && q.en[eif_pkg::BIT_B];
        next_q.a_req  = q.flag[eif_pkg::BIT_A] && q.en[eif_pkg::BIT_A];
        next_q.irq    = |(q.ist & q.imask);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.wreq <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign avs_readdata          = q.rdata;
    assign avs_waitrequest       = q.wreq;
    assign direct_transition_req = q.dt_req;
    assign wakeup_req            = q.wk_req;
    assign ext_req_b_req         = q.b_req;
    assign ext_req_a_req         = q.a_req;
    assign irq                   = q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    dt_req_gate_a: assert property (
        (q.flag[eif_pkg::BIT_DT] && q.en[eif_pkg::BIT_DT]) |=> direct_transition_req)
        else $error("direct transition request missing");
    dt_req_off_a: assert property (
        !(q.flag[eif_pkg::BIT_DT] && q.en[eif_pkg::BIT_DT]) |=> !direct_transition_req)
        else $error("direct transition request without flag and enable");
    wake_req_or_a: assert property (
        (!q.en[eif_pkg::BIT_WP] || q.wflag == 6'h00) |=> !wakeup_req)
        else $error("wakeup request without enabled flag");
    ext_req_gate_a: assert property (
        (q.flag[eif_pkg::BIT_B] && q.en[eif_pkg::BIT_B]) ##1 1'b1 |-> ext_req_b_req)
        else $error("ext b request missing");
    en_fixed_bits_a: assert property (
        (req && q.wreq && at(avs_address, eif_pkg::ADDR_ENABLE))
        |=> avs_readdata[4] && !avs_readdata[6] && avs_readdata[2:1] == 2'b00)
        else $error("enable fixed bits wrong");
    set_wins_a: assert property (
        (hit[eif_pkg::PIN_A] && wr_ok && at(avs_address, eif_pkg::ADDR_FLAG))
        |=> q.flag[eif_pkg::BIT_A])
        else $error("request lost under clearing write");
    dt_flag_set_a: assert property (
        (sleep_exec && q.dt_ctrl) |=> q.flag[eif_pkg::BIT_DT] ##1 1'b1)
        else $error("sleep did not set direct transition flag");
    flag_clear_a: assert property (
        (wr_ok && at(avs_address, eif_pkg::ADDR_FLAG) && !wd[eif_pkg::BIT_B]
         && !hit[eif_pkg::PIN_B]) |=> !q.flag[eif_pkg::BIT_B])
        else $error("flag b not cleared by write 0");
    fall_sets_b_a: assert property (
        ($fell(q.sync2[eif_pkg::PIN_B]) && !q.esel[eif_pkg::BIT_B] && q.pmode[eif_pkg::BIT_B])
        |=> q.flag[eif_pkg::BIT_B])
        else $error("falling edge did not set flag b");
    rise_sets_wake_a: assert property (
        ($rose(q.sync2[eif_pkg::PIN_WK0]) && q.wsel[0] && q.wmode[0]) |=> q.wflag[0])
        else $error("rising edge did not set wakeup flag 0");
    flag_fixed_bits_a: assert property (
        (req && q.wreq && at(avs_address, eif_pkg::ADDR_FLAG))
        |=> avs_readdata[5:4] == 2'b11 && !avs_readdata[6] && avs_readdata[2:1] == 2'b00)
        else $error("flag fixed bits wrong");
    undesignated_a: assert property (
        (!q.pmode[eif_pkg::BIT_A] && !q.flag[eif_pkg::BIT_A]) |=> !q.flag[eif_pkg::BIT_A])
        else $error("undesignated pin set flag a");
    ext_a_gate_a: assert property (
        (q.flag[eif_pkg::BIT_A] && q.en[eif_pkg::BIT_A]) |=> ext_req_a_req)
        else $error("ext a request missing");
    ext_a_off_a: assert property (
        !q.en[eif_pkg::BIT_A] |=> !ext_req_a_req)
        else $error("ext a request while disabled");
    ext_b_off_a: assert property (
        !q.en[eif_pkg::BIT_B] |=> !ext_req_b_req)
        else $error("ext b request while disabled");
    wake_req_set_a: assert property (
        (q.en[eif_pkg::BIT_WP] && q.wflag != 6'h00) |=> wakeup_req)
        else $error("enabled wakeup flag gave no request");
    en_unused_a: assert property (
        (q.en & ~eif_pkg::EN_WR_MASK) == 8'h00)
        else $error("unused enable bit stored");
    flag_unused_a: assert property (
        (q.flag & ~eif_pkg::FLAG_MASK) == 8'h00)
        else $error("unused flag bit stored");
    write_no_set_a: assert property (
        (wr_ok && at(avs_address, eif_pkg::ADDR_FLAG) && !q.flag[eif_pkg::BIT_A]
         && !hit[eif_pkg::PIN_A]) |=> !q.flag[eif_pkg::BIT_A])
        else $error("write set flag a");
    dt_flag_clear_a: assert property (
        (wr_ok && at(avs_address, eif_pkg::ADDR_FLAG) && !wd[eif_pkg::BIT_DT] && !ev_dt)
        |=> !q.flag[eif_pkg::BIT_DT])
        else $error("flag dt not cleared by write 0");
    fall_sets_a_a: assert property (
        ($fell(q.sync2[eif_pkg::PIN_A]) && !q.esel[eif_pkg::BIT_A] && q.pmode[eif_pkg::BIT_A])
        |=> q.flag[eif_pkg::BIT_A])
        else $error("falling edge did not set flag a");
    rise_sets_a_a: assert property (
        ($rose(q.sync2[eif_pkg::PIN_A]) && q.esel[eif_pkg::BIT_A] && q.pmode[eif_pkg::BIT_A])
        |=> q.flag[eif_pkg::BIT_A])
        else $error("rising edge did not set flag a");
    undesig_wake_a: assert property (
        (q.wmode == 6'h00 && q.wflag == 6'h00) |=> q.wflag == 6'h00)
        else $error("undesignated wakeup pin set a flag");

endmodule : eif_unit
`default_nettype wire

//--- verification/eif_pins_model.sv
`default_nettype none
module eif_pins_model (
    // Clock
    input  wire logic       sys_clk,
    // Pins and CPU sleep pulse
    output wire logic       ext_req_a_pin,
    output wire logic       ext_req_b_pin,
    output wire logic [5:0] wakeup_pins,
    output var  logic       sleep_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pins = 8'hFF;
    initial sleep_exec = 1'b0;
    assign ext_req_a_pin = pins[eif_pkg::PIN_A];
    assign ext_req_b_pin = pins[eif_pkg::PIN_B];
    assign wakeup_pins   = pins[eif_pkg::PIN_WK0 +: eif_pkg::NWAKE];
    // Four cycles per level, above the two the synchroniser needs
    task automatic drive(input int idx, input logic lvl);
        @(posedge sys_clk);
        pins[idx] <= lvl;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic pulse(input int idx);
        drive(idx, 1'b0);
        drive(idx, 1'b1);
    endtask
    // One-cycle pulse as one sleep instruction
    task automatic sleep_pulse();
        @(posedge sys_clk);
        sleep_exec <= 1'b1;
        @(posedge sys_clk);
        sleep_exec <= 1'b0;
    endtask
endmodule // eif_pins_model
`default_nettype wire

//--- verification/eif_unit_tb.sv
`default_nettype none
module eif_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, sleep_exec, dt_req, wk_req, b_req, a_req, irq;
    logic pin_a, pin_b;
    logic [5:0] wk_pins;
    // Selectors into the output level vector
    localparam int L_IRQ = 0;
    localparam int L_A   = 1;
    localparam int L_B   = 2;
    localparam int L_WK  = 3;
    localparam int L_DT  = 4;
    wire logic [4:0] lvls;
    assign lvls = {dt_req, wk_req, b_req, a_req, irq};
    int err_count = 0;
    int comparisons = 0;
    always #12.5 sys_clk = ~sys_clk;
    eif_unit i_eif_unit (
        .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sleep_exec(sleep_exec), .direct_transition_req(dt_req), .wakeup_req(wk_req),
        .ext_req_b_req(b_req), .ext_req_a_req(a_req), .irq(irq),
        .ext_req_a_pin(pin_a), .ext_req_b_pin(pin_b), .wakeup_pins(wk_pins));
    eif_pins_model i_eif_pins_model (
        .sys_clk(sys_clk), .ext_req_a_pin(pin_a), .ext_req_b_pin(pin_b),
        .wakeup_pins(wk_pins), .sleep_exec(sleep_exec));
    // ************************************************************
    // Bus access and comparison
    // ************************************************************
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("CHECK FAILED t=%0t bus hang addr=%h", $time, a);
        end
        q = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Output levels lag their flag, enable or status register by a cycle, so let two edges pass
    // Level is read after the wait, not copied at the call
    task automatic chk_lvl(input int sel, input logic exp);
        repeat (2) @(posedge sys_clk);
        chk_reg({7'h00, lvls[sel]}, {7'h00, exp});
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk_reg(q, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk(eif_pkg::ADDR_ENABLE, 8'h10);
        rchk(eif_pkg::ADDR_FLAG, 8'h30);
        rchk(eif_pkg::ADDR_WAKEFLAG, 8'hC0);
        rchk(6'h3C, 8'h00);
        wr(eif_pkg::ADDR_ENABLE, 8'hFF);
        rchk(eif_pkg::ADDR_ENABLE, 8'hB9);
        // Lane 0 disabled: the write must be ignored
        avs_byteenable <= 4'hE;
        wr(eif_pkg::ADDR_ENABLE, 8'h00);
        avs_byteenable <= 4'hF;
        rchk(eif_pkg::ADDR_ENABLE, 8'hB9);
        $display("test reset_and_fixed done");
        wr(eif_pkg::ADDR_PINMODE, 8'h09);
        wr(eif_pkg::ADDR_WAKEMODE, 8'h3F);
        wr(eif_pkg::ADDR_IRQMASK, 8'h0F);
        i_eif_pins_model.pulse(eif_pkg::PIN_A);
        rchk(eif_pkg::ADDR_FLAG, 8'h31);
        chk_lvl(L_A, 1'b1);
        chk_lvl(L_IRQ, 1'b1);
        i_eif_pins_model.pulse(eif_pkg::PIN_B);
        rchk(eif_pkg::ADDR_FLAG, 8'h39);
        chk_lvl(L_B, 1'b1);
        wr(eif_pkg::ADDR_FLAG, 8'hFF);
        rchk(eif_pkg::ADDR_FLAG, 8'h39);
        wr(eif_pkg::ADDR_FLAG, 8'h08);
        rchk(eif_pkg::ADDR_FLAG, 8'h38);
        chk_lvl(L_A, 1'b0);
        wr(eif_pkg::ADDR_FLAG, 8'h00);
        rchk(eif_pkg::ADDR_FLAG, 8'h30);
        chk_lvl(L_B, 1'b0);
        $display("test ext_pins done");
        rchk(eif_pkg::ADDR_IRQSTAT, 8'h0C);
        rchk(eif_pkg::ADDR_IRQSTAT, 8'h00);
        chk_lvl(L_IRQ, 1'b0);
        $display("test status_clear done");
        wr(eif_pkg::ADDR_EDGESEL, 8'h01);
        i_eif_pins_model.drive(eif_pkg::PIN_A, 1'b0);
        rchk(eif_pkg::ADDR_FLAG, 8'h30);
        i_eif_pins_model.drive(eif_pkg::PIN_A, 1'b1);
        rchk(eif_pkg::ADDR_FLAG, 8'h31);
        wr(eif_pkg::ADDR_FLAG, 8'h00);
        wr(eif_pkg::ADDR_PINMODE, 8'h00);
        i_eif_pins_model.pulse(eif_pkg::PIN_B);
        rchk(eif_pkg::ADDR_FLAG, 8'h30);
        $display("test edge_and_mode done");
        wr(eif_pkg::ADDR_SYSCTL, 8'h01);
        i_eif_pins_model.sleep_pulse();
        rchk(eif_pkg::ADDR_FLAG, 8'hB0);
        chk_lvl(L_DT, 1'b1);
        wr(eif_pkg::ADDR_ENABLE, 8'h29);
        chk_lvl(L_DT, 1'b0);
        i_eif_pins_model.pulse(eif_pkg::PIN_WK0 + 2);
        rchk(eif_pkg::ADDR_WAKEFLAG, 8'hC4);
        chk_lvl(L_WK, 1'b1);
        wr(eif_pkg::ADDR_ENABLE, 8'h09);
        chk_lvl(L_WK, 1'b0);
        $display("test sleep_and_wakeup done");
        chk_lvl(L_IRQ, 1'b1);
        wr(eif_pkg::ADDR_IRQMASK, 8'h00);
        chk_lvl(L_IRQ, 1'b0);
        rchk(eif_pkg::ADDR_IRQSTAT, 8'h0B);
        $display("test irq_mask done");
        wr(eif_pkg::ADDR_PINMODE, 8'h09);
        wr(eif_pkg::ADDR_EDGESEL, 8'h00);
        // Clearing write lands on the edge at which the falling pin edge sets flag 0
        fork
            i_eif_pins_model.pulse(eif_pkg::PIN_A);
            begin
                @(posedge sys_clk);
                wr(eif_pkg::ADDR_FLAG, 8'h00);
            end
        join
        rchk(eif_pkg::ADDR_FLAG, 8'h31);
        chk_lvl(L_A, 1'b1);
        wr(eif_pkg::ADDR_ENABLE, 8'h08);
        chk_lvl(L_A, 1'b0);
        wr(eif_pkg::ADDR_WAKEEDGE, 8'h01);
        i_eif_pins_model.pulse(eif_pkg::PIN_WK0);
        rchk(eif_pkg::ADDR_WAKEFLAG, 8'hC5);
        $display("test collision_and_rise done");
        give_verdict();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end
endmodule // eif_unit_tb
`default_nettype wire
